// [shared/trig_gen_pkg.sv]
// Constants and types for the trigger list generator
package trig_gen_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int MEM_AW = 6;
  localparam int CNT_W = 6;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LIST0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LIST1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DEBUG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NEXTV = 8'h1C;
  // Status / enable layout
  localparam int BIT_REL_ERR = 0;
  localparam int BIT_TIM_ERR = 1;
  localparam int BIT_DONE = 2;
  localparam int NUM_EV = 3;
  // Control layout
  localparam int BIT_GEN_EN = 0;
  localparam int BIT_LOAD_OK = 1;
  // Debug layout
  localparam int BIT_LIST = 8;
  localparam logic [VAL_W-1:0] END_MARK = 16'h0000;
  localparam logic [CNT_W-1:0] MAX_TRIG = 6'h20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  // Memory read latency of one value fetch, in bus cycles
  localparam logic [1:0] FETCH_CYC = 2'h2;
  localparam logic [VAL_W-1:0] VAL_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] UNMAPPED = 32'h00000000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_HALT = 4'b1000
  } gen_state_t;
endpackage

// [core/trig_gen.sv]
// Trigger list generator with error, done and debug status
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
// Functional notes
// - Error recovery at next reload; async reload silent
// - ECC-bad value discarded, no reload error
// - Spacing of one gives timing error, except on the fetch after the 32nd trigger
// - Fetched value below counter sets timing error
// - Timing error halts list until reload
// - Decreasing or late values give timing error
// - ECC-bad value leaves timing error clear
// - Error enable raises interrupt on timing error
// - Done on zero value or 32 triggers
// - Done rises one fetch after last trigger
// - Done enable raises interrupt on done
// - ECC-bad value leaves done flag clear
// - Debug shows active list
// - Debug count since reload, zero at maximum
// - Debug shows next fetched value
// - Debug views frozen after list finishes
// - Reload clears count; sync reload swaps list on load-ok
module trig_gen
  import trig_gen_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reload_i,
  input wire logic async_reload_i,
  input wire logic [VAL_W-1:0] counter_i,
  output logic mem_rd_o,
  output logic [MEM_AW-1:0] mem_adr_o,
  input wire logic [VAL_W-1:0] mem_dat_i,
  input wire logic double_bit_ecc_flag_i,
  output logic trigger_o,
  output logic irq_o
);

  typedef struct packed {
    gen_state_t st;
    logic gen_en;
    logic list_swap_load_ok;
    logic [MEM_AW-1:0] base0;
    logic [MEM_AW-1:0] base1;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] enable;
    logic active_list_view;
    logic [CNT_W-1:0] trigger_count_view;
    logic [VAL_W-1:0] next_value_view;
    logic [VAL_W-1:0] prev_value;
    logic first;
    logic [1:0] wait_cnt;
    logic [MEM_AW-1:0] ptr;
    logic mem_rd;
    logic trigger;
    logic irq;
    logic ack;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t r;
  state_t next_r;

  // -----------------------------------------------------------------
  // Register read mux
  // -----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] read_reg(input state_t s, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    d = UNMAPPED;
    unique case (a)
      OFS_CTRL: begin
        d[BIT_GEN_EN] = s.gen_en;
        d[BIT_LOAD_OK] = s.list_swap_load_ok;
      end
      OFS_STATUS: d[NUM_EV-1:0] = s.status;
      OFS_ENABLE: d[NUM_EV-1:0] = s.enable;
      OFS_LIST0: d[MEM_AW-1:0] = s.base0;
      OFS_LIST1: d[MEM_AW-1:0] = s.base1;
      OFS_DEBUG: begin
        d[CNT_W-1:0] = s.trigger_count_view;
        d[BIT_LIST] = s.active_list_view;
      end
      OFS_NEXTV: d[VAL_W-1:0] = s.next_value_view;
      default: d = UNMAPPED;
    endcase
    return d;
  endfunction

  // Memory data is valid only in the last fetch cycle
  function automatic logic at_sample(input state_t s);
    return s.st == ST_FETCH && s.wait_cnt == 2'h0;
  endfunction

  logic bus_req;
  logic bus_wr;
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_EV-1:0] ev_clr;
  logic sel_list;
  logic [CNT_W-1:0] cnt_inc;
  // No reload and not frozen: the sequencer acts alone
  logic quiet;

  always_comb begin
    next_r = r;
    ev_set = '0;
    ev_clr = '0;
    next_r.trigger = 1'b0;
    next_r.mem_rd = 1'b0;
    bus_req = wb_cyc_i && wb_stb_i && !r.ack;
    bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    cnt_inc = r.trigger_count_view + 6'h01;
    sel_list = r.active_list_view;

    // ---------------------------------------------------------------
    // Wishbone slave, one wait state, ack drops after one cycle
    // ---------------------------------------------------------------
    next_r.ack = bus_req;
    next_r.rdata = bus_req ? read_reg(r, wb_adr_i) : r.rdata;
    if (bus_wr) begin
      unique case (wb_adr_i)
        OFS_CTRL: begin
          next_r.gen_en = wb_dat_i[BIT_GEN_EN];
          next_r.list_swap_load_ok = wb_dat_i[BIT_LOAD_OK];
        end
        OFS_CLEAR: ev_clr = wb_dat_i[NUM_EV-1:0];
        OFS_ENABLE: next_r.enable = wb_dat_i[NUM_EV-1:0];
        OFS_LIST0: next_r.base0 = wb_dat_i[MEM_AW-1:0];
        OFS_LIST1: next_r.base1 = wb_dat_i[MEM_AW-1:0];
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    unique case (r.st)
      ST_IDLE, ST_HALT: ;
      ST_FETCH: begin
        if (r.wait_cnt != 2'h0) begin
          next_r.wait_cnt = r.wait_cnt - 2'h1;
        end else if (double_bit_ecc_flag_i) begin
          next_r.st = ST_HALT;
        end else begin
          next_r.next_value_view = mem_dat_i;
          next_r.prev_value = mem_dat_i;
          if (mem_dat_i == END_MARK || r.trigger_count_view == MAX_TRIG) begin
            ev_set[BIT_DONE] = 1'b1;
            next_r.st = ST_HALT;
            if (r.trigger_count_view == MAX_TRIG) begin
              next_r.trigger_count_view = CNT_ZERO;
            end
          end else if (mem_dat_i < counter_i ||
                       (!r.first && mem_dat_i < r.prev_value) ||
                       (!r.first && mem_dat_i - r.prev_value == VAL_ONE)) begin
            ev_set[BIT_TIM_ERR] = 1'b1;
            next_r.st = ST_HALT;
          end else begin
            next_r.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (counter_i == r.next_value_view) begin
          next_r.trigger = 1'b1;
          next_r.trigger_count_view = cnt_inc;
          next_r.first = 1'b0;
          next_r.ptr = r.ptr + 6'h01;
          next_r.mem_rd = 1'b1;
          next_r.wait_cnt = FETCH_CYC;
          next_r.st = ST_FETCH;
        end else if (counter_i > r.next_value_view) begin
          ev_set[BIT_TIM_ERR] = 1'b1;
          next_r.st = ST_HALT;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // ---------------------------------------------------------------
    // Reload overrides any sequence in progress
    // ---------------------------------------------------------------
    if ((reload_i || async_reload_i) && r.gen_en) begin
      if (reload_i && r.list_swap_load_ok) begin
        sel_list = !r.active_list_view;
        next_r.list_swap_load_ok = 1'b0;
      end
      if (reload_i && !async_reload_i && (r.st == ST_FETCH || r.st == ST_WAIT)) begin
        ev_set[BIT_REL_ERR] = 1'b1;
      end
      next_r.active_list_view = sel_list;
      next_r.trigger_count_view = CNT_ZERO;
      next_r.ptr = sel_list ? r.base1 : r.base0;
      next_r.first = 1'b1;
      next_r.mem_rd = 1'b1;
      next_r.wait_cnt = FETCH_CYC;
      next_r.st = ST_FETCH;
    end

    // ---------------------------------------------------------------
    // Status flags and interrupt
    // ---------------------------------------------------------------
    // Set wins over software clear
    next_r.status = (r.status & ~ev_clr) | ev_set;
    next_r.irq = |(next_r.status & r.enable);
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= ST_IDLE;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // -----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // -----------------------------------------------------------------
  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign mem_rd_o = r.mem_rd;
  assign mem_adr_o = r.ptr;
  assign trigger_o = r.trigger;
  assign irq_o = r.irq;
  assign quiet = ce_i && !reload_i && !async_reload_i;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_ecc_no_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && r.st == ST_FETCH && r.wait_cnt == 2'h0 && double_bit_ecc_flag_i &&
     !reload_i && !async_reload_i) |=> !$rose(r.status[BIT_DONE]))
    else $error("done set on ecc value");
  a_ecc_no_terr: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && r.st == ST_FETCH && r.wait_cnt == 2'h0 && double_bit_ecc_flag_i &&
     !reload_i && !async_reload_i) |=> !$rose(r.status[BIT_TIM_ERR]))
    else $error("timing error on ecc value");
  a_terr_halts: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(r.status[BIT_TIM_ERR]) && r.st == ST_HALT |-> !r.trigger)
    else $error("trigger after timing error");
  a_low_value: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && r.st == ST_FETCH && r.wait_cnt == 2'h0 && !double_bit_ecc_flag_i &&
     !reload_i && !async_reload_i && mem_dat_i != END_MARK &&
     r.trigger_count_view != MAX_TRIG && mem_dat_i < counter_i)
    |=> r.status[BIT_TIM_ERR] && r.st == ST_HALT)
    else $error("low value not flagged");
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ce_i) |-> irq_o == |(r.status & $past(r.enable)))
    else $error("irq mismatch");
  a_reload_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reload_i && r.gen_en) |=> r.trigger_count_view == CNT_ZERO && r.st == ST_FETCH)
    else $error("reload did not restart");
  a_async_silent: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && async_reload_i && !r.status[BIT_REL_ERR]) |=> !r.status[BIT_REL_ERR])
    else $error("async reload set reload error");
  a_trig_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && r.st == ST_WAIT && counter_i == r.next_value_view && !reload_i && !async_reload_i)
    |=> trigger_o && r.trigger_count_view == $past(cnt_inc))
    else $error("match did not trigger");
  a_done_later: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(r.status[BIT_DONE]) |-> !trigger_o)
    else $error("done with trigger");
  a_views_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == ST_HALT && !reload_i && !async_reload_i) |=> $stable(r.next_value_view))
    else $error("views changed after finish");

  // -----------------------------------------------------------------
  // Bus handshake checks
  // -----------------------------------------------------------------
  // Classic cycle: one wait state, ack never stretched
  a_wb_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_wb_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // A clear in the same cycle as an event must not lose it
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (|ev_set) |=> (r.status & $past(ev_set)) == $past(ev_set))
    else $error("event lost to clear");

  // -----------------------------------------------------------------
  // Error checks
  // -----------------------------------------------------------------
  a_ecc_discard: assert property (@(posedge clk_i) disable iff (rst_i)
    at_sample(r) && double_bit_ecc_flag_i && quiet
    |=> r.st == ST_HALT && $stable(r.next_value_view))
    else $error("ecc value not discarded");
  a_spacing_one: assert property (@(posedge clk_i) disable iff (rst_i)
    at_sample(r) && !double_bit_ecc_flag_i && quiet && !r.first &&
    mem_dat_i != END_MARK && r.trigger_count_view != MAX_TRIG &&
    mem_dat_i - r.prev_value == VAL_ONE |=> r.status[BIT_TIM_ERR] && r.st == ST_HALT)
    else $error("spacing of one not flagged");
  a_descend_err: assert property (@(posedge clk_i) disable iff (rst_i)
    at_sample(r) && !double_bit_ecc_flag_i && quiet && !r.first &&
    mem_dat_i != END_MARK && r.trigger_count_view != MAX_TRIG &&
    mem_dat_i < r.prev_value |=> r.status[BIT_TIM_ERR] && r.st == ST_HALT)
    else $error("falling value not flagged");
  // Counter passing the value means the fetch ran late
  a_late_match: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet && r.st == ST_WAIT && counter_i > r.next_value_view
    |=> r.status[BIT_TIM_ERR] && r.st == ST_HALT)
    else $error("late value not flagged");
  // Only a reload may leave the halt state
  a_halt_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet && r.st == ST_HALT |=> r.st == ST_HALT && !r.mem_rd)
    else $error("halted list resumed without reload");
  a_err_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ce_i) && r.status[BIT_TIM_ERR] && $past(r.enable[BIT_TIM_ERR]) |-> irq_o)
    else $error("timing error without interrupt");
  a_rerr_running: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reload_i && !async_reload_i && r.gen_en && (r.st == ST_FETCH || r.st == ST_WAIT)
    |=> r.status[BIT_REL_ERR])
    else $error("reload into running list not flagged");
  a_async_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && async_reload_i && r.gen_en
    |=> r.st == ST_FETCH && mem_rd_o)
    else $error("async reload did not restart");

  // -----------------------------------------------------------------
  // Done and debug view checks
  // -----------------------------------------------------------------
  a_zero_done: assert property (@(posedge clk_i) disable iff (rst_i)
    at_sample(r) && !double_bit_ecc_flag_i && quiet && mem_dat_i == END_MARK
    |=> r.status[BIT_DONE] && r.st == ST_HALT)
    else $error("end mark did not finish list");
  // Count view wraps to zero when the maximum is reached
  a_max_done: assert property (@(posedge clk_i) disable iff (rst_i)
    at_sample(r) && !double_bit_ecc_flag_i && quiet && r.trigger_count_view == MAX_TRIG
    |=> r.status[BIT_DONE] && r.trigger_count_view == CNT_ZERO)
    else $error("maximum count did not finish list");
  a_done_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ce_i) && r.status[BIT_DONE] && $past(r.enable[BIT_DONE]) |-> irq_o)
    else $error("done without interrupt");
  a_next_view: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && at_sample(r) && !double_bit_ecc_flag_i |=> r.next_value_view == $past(mem_dat_i))
    else $error("next value view not loaded");
  a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet && r.st == ST_HALT
    |=> $stable(r.trigger_count_view) && $stable(r.active_list_view))
    else $error("count or list view changed after finish");

  // -----------------------------------------------------------------
  // Reload and trigger checks
  // -----------------------------------------------------------------
  a_list_swap: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reload_i && r.gen_en && r.list_swap_load_ok
    |=> r.active_list_view != $past(r.active_list_view))
    else $error("list not swapped");
  a_list_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reload_i && r.gen_en && !r.list_swap_load_ok |=> $stable(r.active_list_view))
    else $error("list swapped without load ok");
  a_idle_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !r.gen_en && r.st == ST_IDLE |=> r.st == ST_IDLE)
    else $error("disabled generator started");
  a_trig_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && trigger_o |=> !trigger_o)
    else $error("trigger longer than one cycle");
  a_trig_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
    trigger_o |-> mem_rd_o && r.st == ST_FETCH)
    else $error("trigger without next fetch");
  a_rd_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet && mem_rd_o |=> !mem_rd_o)
    else $error("memory read longer than one cycle");
endmodule

// [tb/list_mem.sv]
// Trigger list memory model with double-bit error injection
`timescale 1ns/1ns
module list_mem
  import trig_gen_pkg::*;
(
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [MEM_AW-1:0] adr_i,
  input wire logic [MEM_AW-1:0] bad_adr_i,
  output logic [VAL_W-1:0] dat_o,
  output logic ecc_o
);
  logic [VAL_W-1:0] cells [2**MEM_AW];
  logic [2:0] hold = 3'h0;
  initial begin
    dat_o = 16'h0000;
    ecc_o = 1'b0;
  end
  // Stale data is inverted every cycle after the hold, so a late sample sees a valid value only every other cycle
  always @(posedge clk_i) begin
    if (rd_i) begin
      dat_o <= cells[adr_i];
      ecc_o <= (adr_i == bad_adr_i);
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end else begin
      dat_o <= ~dat_o;
      ecc_o <= 1'b0;
    end
  end
endmodule

// [tb/test_trigger_list_generator_errors.sv]
// Self-checking bench for the trigger list generator
`timescale 1ns/1ns
module test_trigger_list_generator_errors;
  import trig_gen_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rel = 1'b0, arel = 1'b0;
  logic ack, mrd, mecc, trig, irq;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat, q;
  logic [VAL_W-1:0] cnt = '0, mdat;
  logic [MEM_AW-1:0] madr, bad = 6'h3F;
  int mismatches = 0, tests_run = 0, trig_n = 0, cycles = 0;

  trig_gen uut(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .reload_i(rel), .async_reload_i(arel), .counter_i(cnt),
    .mem_rd_o(mrd), .mem_adr_o(madr), .mem_dat_i(mdat), .double_bit_ecc_flag_i(mecc),
    .trigger_o(trig), .irq_o(irq));
  list_mem mem(.clk_i(clk_i), .rd_i(mrd), .adr_i(madr), .bad_adr_i(bad), .dat_o(mdat),
    .ecc_o(mecc));

  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Counter restarts with each synchronous reload, like the PWM counter
  always @(posedge clk_i) begin
    cnt <= rel ? 16'h0000 : cnt + 16'h0001;
    if (trig === 1'b1) trig_n++;
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task go(input int n);
    wb(1'b1, OFS_CLEAR, 32'h7);
    trig_n = 0;
    @(posedge clk_i);
    rel <= 1'b1;
    @(posedge clk_i);
    rel <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_full();
    go(330);
    chk("triggers", 32'h20, 32'(trig_n));
    rd("status", OFS_STATUS, 32'h4);
    rd("count", OFS_DEBUG, 32'h0);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, OFS_ENABLE, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, OFS_ENABLE, 32'h7);
  endtask
  task s_swap();
    wb(1'b1, OFS_CTRL, 32'h3);
    go(60);
    chk("triggers", 32'h2, 32'(trig_n));
    rd("status", OFS_STATUS, 32'h4);
    rd("debug", OFS_DEBUG, 32'h102);
    repeat (30) @(posedge clk_i);
    rd("debug held", OFS_DEBUG, 32'h102);
    rd("ctrl", OFS_CTRL, 32'h1);
  endtask
  task s_timing();
    wb(1'b1, OFS_LIST1, 32'h28);
    go(120);
    chk("triggers", 32'h1, 32'(trig_n));
    rd("status", OFS_STATUS, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    rd("next", OFS_NEXTV, 32'h11);
  endtask
  task s_order();
    wb(1'b1, OFS_LIST1, 32'h38);
    go(60);
    chk("triggers", 32'h1, 32'(trig_n));
    rd("status", OFS_STATUS, 32'h2);
    wb(1'b1, OFS_LIST1, 32'h3C);
    go(60);
    chk("triggers", 32'h1, 32'(trig_n));
    rd("status", OFS_STATUS, 32'h2);
    rd("next", OFS_NEXTV, 32'h23);
  endtask
  task s_ecc();
    wb(1'b1, OFS_LIST1, 32'h30);
    bad <= 6'h30;
    go(60);
    chk("triggers", 32'h0, 32'(trig_n));
    rd("status", OFS_STATUS, 32'h0);
    rd("next kept", OFS_NEXTV, 32'h23);
    bad <= 6'h3F;
    go(60);
    chk("triggers", 32'h2, 32'(trig_n));
    rd("status", OFS_STATUS, 32'h4);
  endtask
  task s_reload();
    go(5);
    arel <= 1'b1;
    @(posedge clk_i);
    arel <= 1'b0;
    repeat (60) @(posedge clk_i);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("async reload", 32'h0, q & 32'h1);
    go(5);
    rel <= 1'b1;
    @(posedge clk_i);
    rel <= 1'b0;
    repeat (60) @(posedge clk_i);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("reload error", 32'h1, q & 32'h1);
  endtask

  initial begin
    for (int i = 0; i < 32; i++) mem.cells[i] = 16'(16 + 8 * i);
    mem.cells[32] = 16'h0010;
    mem.cells[33] = 16'h0018;
    mem.cells[34] = END_MARK;
    mem.cells[40] = 16'h0010;
    mem.cells[41] = 16'h0011;
    mem.cells[42] = 16'h0064;
    mem.cells[48] = 16'h0010;
    mem.cells[49] = 16'h0018;
    mem.cells[50] = END_MARK;
    mem.cells[56] = 16'h0020;
    mem.cells[57] = 16'h0018;
    mem.cells[60] = 16'h0020;
    mem.cells[61] = 16'h0023;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("status", OFS_STATUS, 32'h0);
    rd("debug", OFS_DEBUG, 32'h0);
    rd("unmapped", 8'h20, UNMAPPED);
    wb(1'b1, OFS_ENABLE, 32'h7);
    rd("enable", OFS_ENABLE, 32'h7);
    wb(1'b1, OFS_LIST1, 32'h20);
    wb(1'b1, OFS_CTRL, 32'h1);
    s_full();
    s_swap();
    s_timing();
    s_order();
    s_ecc();
    s_reload();
    finish_test();
  end
endmodule
